// ### sim/rsip_host_model.sv
`default_nettype none
// ----------------------------------------
// Bus host: drives clock, pulls lines low
// ----------------------------------------
module rsip_host_model (
  input wire logic ref_clk,
  input wire logic sda,
  output var logic scl_low,
  output var logic sda_low
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic start();
    cyc(2);
    sda_low = 1'b0;
    cyc(10);
    scl_low = 1'b0;
    cyc(6);
    sda_low = 1'b1;
    cyc(6);
    scl_low = 1'b1;
  endtask
  task automatic stop();
    cyc(2);
    sda_low = 1'b1;
    cyc(10);
    scl_low = 1'b0;
    cyc(6);
    sda_low = 1'b0;
    cyc(12);
  endtask
  // 20-cycle bit, data set while low
  task automatic bit_io(input logic b, output logic r);
    cyc(2);
    sda_low = !b;
    cyc(10);
    scl_low = 1'b0;
    cyc(8);
    r = sda;
    scl_low = 1'b1;
  endtask
  // eight bits msb first, ack slot
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, ack);
  endtask
  task automatic rd_byte(input logic nack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(nack, r);
  endtask
  task automatic spike();
    sda_low = 1'b1;
    cyc(1);
    sda_low = 1'b0;
  endtask
endmodule
`default_nettype wire

// ### sim/rsip_props.sv
`default_nettype none
// ----------------------------------------
// Port checker for the serial target
// ----------------------------------------
module rsip_props #(
  parameter integer REG_AW = 8
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o_r,
  input wire logic sda_oe_r,
  input wire logic busy_r,
  input wire logic [15:0] reg_index_r,
  input wire logic bus_wr_r
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  chk_oe_rise_low: assert property ($rose(sda_oe_r) |-> !scl_i)
    else $error("data drive began with clock high");
  chk_oe_fall_low: assert property ($fell(sda_oe_r) |-> !scl_i)
    else $error("data release with clock high");
  chk_drive_low: assert property (sda_oe_r |-> !sda_o_r)
    else $error("data driven high");
  chk_wr_one_cycle: assert property (bus_wr_r |=> !bus_wr_r)
    else $error("write strobe too long");
  chk_wr_with_ack: assert property (bus_wr_r |-> ##[0:2] sda_oe_r)
    else $error("written byte not acknowledged");
  chk_index_step: assert property (bus_wr_r |-> reg_index_r == $past(reg_index_r) + 16'h0001)
    else $error("index did not step by one");
  chk_start_seen: assert property ($rose(busy_r) |-> scl_i && !sda_i)
    else $error("message began without start");
  chk_stop_seen: assert property ($fell(busy_r) |-> scl_i && sda_i)
    else $error("message ended without stop");
  chk_idle_free: assert property (!busy_r |-> !sda_oe_r)
    else $error("data driven on idle bus");
  chk_wr_in_msg: assert property (bus_wr_r |-> busy_r)
    else $error("write outside a message");
endmodule

bind rsip_i2c_target rsip_props #(.REG_AW(REG_AW)) u_props (
  .ref_clk(ref_clk), .resetn(resetn), .scl_i(scl_i), .sda_i(sda_i), .sda_o_r(sda_o_r),
  .sda_oe_r(sda_oe_r), .busy_r(busy_r), .reg_index_r(reg_index_r), .bus_wr_r(bus_wr_r)
);
`default_nettype wire

// ### sim/testbench.sv
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic ce = 1'b1;
  logic core_we = 1'b0;
  logic [7:0] core_addr = 8'h00;
  logic [7:0] core_wdata = 8'h00;
  logic a;
  logic [7:0] mem [256];
  logic [15:0] exp_q [$];
  int errors = 0;
  int total_checks = 0;
  int cycles = 0;
  wire sda_oe_r, sda_o_r, busy_r, bus_wr_r, scl_low, sda_low;
  wire [15:0] reg_index_r;
  wire [7:0] core_rdata_r;
  // Wired-and bus lines with pull-ups
  wire scl = !scl_low;
  wire sda = !(sda_low || (sda_oe_r && !sda_o_r));
  rsip_i2c_target DUT (
    .ref_clk(ref_clk), .resetn(resetn), .ce(ce), .scl_i(scl), .sda_i(sda), .sda_o_r(sda_o_r),
    .sda_oe_r(sda_oe_r), .busy_r(busy_r), .reg_index_r(reg_index_r), .bus_wr_r(bus_wr_r),
    .core_we(core_we), .core_addr(core_addr), .core_wdata(core_wdata), .core_rdata_r(core_rdata_r)
  );
  rsip_host_model host (.ref_clk(ref_clk), .sda(sda), .scl_low(scl_low), .sda_low(sda_low));
  // Clock, 50 ns period
  initial forever #25 ref_clk = ~ref_clk;
  // Hang guard
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      close_out();
    end
  end
  // Written byte: compare index with oldest note
  always @(posedge ref_clk) begin
    if (bus_wr_r === 1'b1) begin
      if (exp_q.size() == 0)
        check("stray write", 1'b1, 1'b0);
      else
        check("index", reg_index_r, exp_q.pop_front());
    end
  end
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic send(input logic [7:0] b);
    logic k;
    host.wr_byte(b, k);
    check("ack", k, 1'b0);
  endtask
  task automatic set_index(input logic [15:0] idx);
    host.start();
    send(8'h52);
    send(idx[15:8]);
    send(idx[7:0]);
  endtask
  task automatic wr_msg(input logic [15:0] idx, input int n);
    logic [7:0] d;
    set_index(idx);
    for (int k = 0; k < n; k++) begin
      d = 8'($urandom);
      mem[8'(idx + 16'(k))] = d;
      exp_q.push_back(idx + 16'(k) + 16'h0001);
      send(d);
    end
    host.stop();
  endtask
  task automatic rd_msg(input logic [15:0] idx, input int n);
    logic [7:0] d;
    set_index(idx);
    host.start();
    send(8'h53);
    for (int k = 0; k < n; k++) begin
      host.rd_byte(k == n - 1, d);
      check("read data", d, mem[8'(idx + 16'(k))]);
    end
    host.cyc(5);
    check("index after read", reg_index_r, idx + 16'(n));
    check("released", sda_oe_r, 1'b0);
    host.stop();
  endtask
  task automatic close_out();
    if (errors == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    void'($urandom(52));
    for (int i = 0; i < 256; i++) mem[i] = 8'h00;
    repeat (10) @(posedge ref_clk);
    @(negedge ref_clk);
    resetn = 1'b1;
    host.cyc(3);
    check("idle", {sda_oe_r, busy_r}, 2'b00);
    wr_msg(16'h0010, 3);
    wr_msg(16'hFFFF, 1);
    check("idle after stop", busy_r, 1'b0);
    core_we = 1'b1;
    core_addr = 8'h40;
    core_wdata = 8'($urandom);
    mem[8'h40] = core_wdata;
    host.cyc(1);
    core_we = 1'b0;
    core_addr = 8'h11;
    host.cyc(2);
    check("core read", core_rdata_r, mem[8'h11]);
    // Clock enable low freezes store and read register
    ce = 1'b0;
    core_we = 1'b1;
    core_addr = 8'h41;
    core_wdata = 8'($urandom);
    host.cyc(2);
    check("frozen read", core_rdata_r, mem[8'h11]);
    core_we = 1'b0;
    ce = 1'b1;
    host.cyc(2);
    check("frozen write", core_rdata_r, mem[8'h41]);
    rd_msg(16'h0010, 3);
    rd_msg(16'h0040, 1);
    host.start();
    host.wr_byte(8'h50, a);
    check("foreign ack", a, 1'b1);
    host.wr_byte(8'hA5, a);
    check("foreign busy", busy_r, 1'b1);
    host.stop();
    host.spike();
    repeat (6) begin
      host.cyc(1);
      check("spike ignored", busy_r, 1'b0);
    end
    // Reset in mid-run clears index and store
    resetn = 1'b0;
    host.cyc(2);
    resetn = 1'b1;
    for (int i = 0; i < 256; i++) mem[i] = 8'h00;
    core_addr = 8'h10;
    host.cyc(3);
    check("index after reset", reg_index_r, 16'h0000);
    check("store after reset", core_rdata_r, mem[8'h10]);
    close_out();
  end
endmodule
`default_nettype wire

// ### src/rsip_defines.vh
`ifndef RSIP_DEFINES_VH
`define RSIP_DEFINES_VH

// ----------------------------------------------------------------
// Bus addressing
// ----------------------------------------------------------------
// Eight-bit bus address, write and read forms
`define RSIP_ADDR_WR 8'h52
`define RSIP_ADDR_RD 8'h53

// ----------------------------------------------------------------
// Framing
// ----------------------------------------------------------------
// Bits in one byte before the acknowledge slot
`define RSIP_BYTE_BITS 4'h8
// Register index after reset
`define RSIP_IDX_RST 16'h0000
// Reset value of every store byte and of the core read register
`define RSIP_REG_RST 8'h00

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
// Highest supported bus rate in kbit/s
`define RSIP_BUS_RATE_KBPS 1000
// System clock period in ns
`define RSIP_CLK_NS 50
// Widest spike that the input filter removes, in ns
`define RSIP_SPIKE_NS 50
// Spike width in clock cycles, rounded up, at least one
`define RSIP_SPIKE_CYC (((`RSIP_SPIKE_NS + `RSIP_CLK_NS - 1) / `RSIP_CLK_NS) < 1 ? 1 : \
  ((`RSIP_SPIKE_NS + `RSIP_CLK_NS - 1) / `RSIP_CLK_NS))

`endif

// ### src/rsip_glitch_filter.v
`default_nettype none

// Accepts a new input level only after it has stood for more than the spike width
module rsip_glitch_filter #(
  parameter integer SPIKE_CYC = 1
) (
  input wire ref_clk,
  input wire resetn,
  input wire ce,
  input wire din,
  output reg q_r
);

  reg [3:0] cnt_r;

  // ----------------------------------------------------------------
  // Stability counter
  // ----------------------------------------------------------------
  // A level differing from the output must persist SPIKE_CYC+1 samples
  always @(posedge ref_clk) begin
    if (!resetn) begin
      q_r <= 1'b1;
      cnt_r <= 4'h0;
    end else if (ce) begin
      if (din == q_r) begin
        cnt_r <= 4'h0;
      end else if (cnt_r >= SPIKE_CYC[3:0]) begin
        q_r <= din;
        cnt_r <= 4'h0;
      end else begin
        cnt_r <= cnt_r + 4'h1;
      end
    end
  end

endmodule

`default_nettype wire

// ### src/rsip_i2c_target.v
// Behaviour
// - Answer only address 0x52 write, 0x53 read
// - Bus rates up to 1 Mbit/s
// - Eight-bit bytes each followed by acknowledge
// - Receiver of each byte drives acknowledge
// - Sample on rising clock, data stable high
// - Detect start and stop while clock high
// - Acknowledge own address, latch direction bit
// - Write message index bytes form 16-bit index
// - Received byte stored at index as acknowledge starts
// - Read loads register, shifts out on falling
// - Host ends message; device releases data
// - Index increments by one after each data byte
// - Lines only driven low, released for high
// - Suppress bus glitches up to 50 ns
// - Both lines high means idle bus
`include "rsip_defines.vh"
`default_nettype none

module rsip_i2c_target #(
  parameter integer REG_AW = 8,
  parameter integer SPIKE_CYC = `RSIP_SPIKE_CYC
) (
  input wire ref_clk,
  input wire resetn,
  input wire ce,
  input wire scl_i,
  input wire sda_i,
  output reg sda_o_r,
  output reg sda_oe_r,
  output reg busy_r,
  output reg [15:0] reg_index_r,
  output reg bus_wr_r,
  input wire core_we,
  input wire [REG_AW-1:0] core_addr,
  input wire [7:0] core_wdata,
  output wire [7:0] core_rdata_r
);

  // ----------------------------------------------------------------
  // States
  // ----------------------------------------------------------------
  localparam [6:0] ST_IDLE = 7'b000_0001;
  localparam [6:0] ST_ADDR = 7'b000_0010;
  localparam [6:0] ST_RX = 7'b000_0100;
  localparam [6:0] ST_ACK = 7'b000_1000;
  localparam [6:0] ST_TX = 7'b001_0000;
  localparam [6:0] ST_HACK = 7'b010_0000;
  localparam [6:0] ST_SKIP = 7'b100_0000;

  // Write message byte phases
  localparam [1:0] PH_IDX_HI = 2'h0;
  localparam [1:0] PH_IDX_LO = 2'h1;
  localparam [1:0] PH_DATA = 2'h2;

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  // Next register index, wraps at the top of the 16-bit range
  function [15:0] next_index;
    input [15:0] idx;
    begin
      next_index = idx + 16'h0001;
    end
  endfunction

  // Bit to present for a driven data bit: low drives, high releases
  function drive_for;
    input b;
    begin
      drive_for = ~b;
    end
  endfunction

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  wire scl_f;
  wire sda_f;
  wire [7:0] bank_rdata;
  reg scl_d_r;
  reg sda_d_r;
  reg [6:0] state_r;
  reg [6:0] state_nxt;
  reg [7:0] shift_r;
  reg [7:0] shift_nxt;
  reg [3:0] bit_cnt_r;
  reg [3:0] bit_cnt_nxt;
  reg [1:0] phase_r;
  reg [1:0] phase_nxt;
  reg dir_rd_r;
  reg dir_rd_nxt;
  reg sda_oe_nxt;
  reg [15:0] index_nxt;
  reg bus_wr_nxt;
  reg [7:0] wr_data_r;
  reg [7:0] wr_data_nxt;
  reg [15:0] wr_index_r;
  reg [15:0] wr_index_nxt;
  wire scl_rise;
  wire scl_fall;
  wire start_det;
  wire stop_det;

  // ----------------------------------------------------------------
  // Input stage
  // ----------------------------------------------------------------
  // filter both lines
  rsip_glitch_filter #(
    .SPIKE_CYC(SPIKE_CYC)
  ) u_scl_filt (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .ce(ce),
    .din(scl_i),
    .q_r(scl_f)
  );

  rsip_glitch_filter #(
    .SPIKE_CYC(SPIKE_CYC)
  ) u_sda_filt (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .ce(ce),
    .din(sda_i),
    .q_r(sda_f)
  );

  // Previous filtered levels for edge detection
  always @(posedge ref_clk) begin
    if (!resetn) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else if (ce) begin
      scl_d_r <= scl_f;
      sda_d_r <= sda_f;
    end
  end

  // data is taken on rising clock
  assign scl_rise = scl_f && !scl_d_r;
  assign scl_fall = !scl_f && scl_d_r;
  // data edges with clock high frame messages
  assign start_det = scl_f && scl_d_r && sda_d_r && !sda_f;
  assign stop_det = scl_f && scl_d_r && !sda_d_r && sda_f;

  // ----------------------------------------------------------------
  // Register store
  // ----------------------------------------------------------------
  rsip_reg_bank #(
    .AW(REG_AW)
  ) u_bank (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .ce(ce),
    .bus_we(bus_wr_r),
    .bus_addr(bus_wr_r ? wr_index_r[REG_AW-1:0] : reg_index_r[REG_AW-1:0]), // Write slot, else read index
    .bus_wdata(wr_data_r),
    .bus_rdata(bank_rdata),
    .core_we(core_we),
    .core_addr(core_addr),
    .core_wdata(core_wdata),
    .core_rdata_r(core_rdata_r)
  );

  // ----------------------------------------------------------------
  // Protocol engine
  // ----------------------------------------------------------------
  // Next-state logic for the byte and acknowledge sequencer
  always @* begin
    state_nxt = state_r;
    shift_nxt = shift_r;
    bit_cnt_nxt = bit_cnt_r;
    phase_nxt = phase_r;
    dir_rd_nxt = dir_rd_r;
    sda_oe_nxt = sda_oe_r;
    index_nxt = reg_index_r;
    bus_wr_nxt = 1'b0;
    wr_data_nxt = wr_data_r;
    wr_index_nxt = wr_index_r;
    if (start_det) begin
      // a start or restart opens a new message
      // index is left as it stands
      state_nxt = ST_ADDR;
      bit_cnt_nxt = 4'h0;
      phase_nxt = PH_IDX_HI;
      sda_oe_nxt = 1'b0;
    end else if (stop_det) begin
      // release data when the host closes
      state_nxt = ST_IDLE;
      sda_oe_nxt = 1'b0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          sda_oe_nxt = 1'b0;
        end
        ST_ADDR, ST_RX: begin
          if (scl_rise && bit_cnt_r != `RSIP_BYTE_BITS) begin
            shift_nxt = {shift_r[6:0], sda_f};
            bit_cnt_nxt = bit_cnt_r + 4'h1;
          end else if (scl_fall && bit_cnt_r == `RSIP_BYTE_BITS) begin
            bit_cnt_nxt = 4'h0;
            if (state_r == ST_ADDR) begin
              // match own address in either direction
              if ({shift_r[7:1], 1'b0} == `RSIP_ADDR_WR) begin
                dir_rd_nxt = shift_r[0];
                sda_oe_nxt = 1'b1;
                state_nxt = ST_ACK;
              end else begin
                state_nxt = ST_SKIP;
              end
            end else begin
              sda_oe_nxt = 1'b1;
              state_nxt = ST_ACK;
              case (phase_r)
                PH_IDX_HI: begin
                  index_nxt = {shift_r, reg_index_r[7:0]};
                  phase_nxt = PH_IDX_LO;
                end
                PH_IDX_LO: begin
                  index_nxt = {reg_index_r[15:8], shift_r};
                  phase_nxt = PH_DATA;
                end
                default: begin
                  bus_wr_nxt = 1'b1;
                  wr_data_nxt = shift_r;
                  wr_index_nxt = reg_index_r;
                  index_nxt = next_index(reg_index_r);
                end
              endcase
            end
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            if (dir_rd_r) begin
              shift_nxt = bank_rdata;
              sda_oe_nxt = drive_for(bank_rdata[7]);
              bit_cnt_nxt = 4'h0;
              state_nxt = ST_TX;
            end else begin
              sda_oe_nxt = 1'b0;
              state_nxt = ST_RX;
            end
          end
        end
        ST_TX: begin
          // next bit on each falling clock
          if (scl_fall) begin
            if (bit_cnt_r == `RSIP_BYTE_BITS - 4'h1) begin
              sda_oe_nxt = 1'b0;
              state_nxt = ST_HACK;
            end else begin
              shift_nxt = {shift_r[6:0], 1'b1};
              sda_oe_nxt = drive_for(shift_r[6]);
              bit_cnt_nxt = bit_cnt_r + 4'h1;
            end
          end
        end
        ST_HACK: begin
          if (scl_rise) begin
            index_nxt = next_index(reg_index_r);
            dir_rd_nxt = !sda_f;
          end else if (scl_fall) begin
            if (dir_rd_r) begin
              shift_nxt = bank_rdata;
              sda_oe_nxt = drive_for(bank_rdata[7]);
              bit_cnt_nxt = 4'h0;
              state_nxt = ST_TX;
            end else begin
              sda_oe_nxt = 1'b0;
              state_nxt = ST_SKIP;
            end
          end
        end
        ST_SKIP: begin
          // Wait for stop or restart with data released
          sda_oe_nxt = 1'b0;
        end
        default: begin
          state_nxt = ST_IDLE;
          sda_oe_nxt = 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State registers
  // ----------------------------------------------------------------
  // the data pin only ever drives low
  always @(posedge ref_clk) begin
    if (!resetn) begin
      state_r <= ST_IDLE;
      shift_r <= 8'h00;
      bit_cnt_r <= 4'h0;
      phase_r <= PH_IDX_HI;
      dir_rd_r <= 1'b0;
      sda_o_r <= 1'b0;
      sda_oe_r <= 1'b0;
      busy_r <= 1'b0;
      reg_index_r <= `RSIP_IDX_RST;
      bus_wr_r <= 1'b0;
      wr_data_r <= 8'h00;
      wr_index_r <= `RSIP_IDX_RST;
    end else if (ce) begin
      state_r <= state_nxt;
      shift_r <= shift_nxt;
      bit_cnt_r <= bit_cnt_nxt;
      phase_r <= phase_nxt;
      dir_rd_r <= dir_rd_nxt;
      sda_o_r <= 1'b0;
      sda_oe_r <= sda_oe_nxt;
      busy_r <= (state_nxt != ST_IDLE);
      reg_index_r <= index_nxt;
      bus_wr_r <= bus_wr_nxt;
      wr_data_r <= wr_data_nxt;
      wr_index_r <= wr_index_nxt;
    end
  end

  // filter delay of two cycles fits a 10-cycle low phase at 1 Mbit/s

endmodule

`default_nettype wire

// ### src/rsip_reg_bank.v
`include "rsip_defines.vh"
`default_nettype none

// Byte-wide register store, one port for the serial side and one for the core
module rsip_reg_bank #(
  parameter integer AW = 8
) (
  input wire ref_clk,
  input wire resetn,
  input wire ce,
  input wire bus_we,
  input wire [AW-1:0] bus_addr,
  input wire [7:0] bus_wdata,
  output wire [7:0] bus_rdata,
  input wire core_we,
  input wire [AW-1:0] core_addr,
  input wire [7:0] core_wdata,
  output reg [7:0] core_rdata_r
);

  localparam integer DEPTH = 1 << AW;

  reg [7:0] mem_r [0:DEPTH-1];
  integer i;

  // Serial side reads without delay so a byte can load on the same edge
  assign bus_rdata = mem_r[bus_addr];

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  // Serial side wins when both ports write the same byte
  always @(posedge ref_clk) begin
    if (!resetn) begin
      for (i = 0; i < DEPTH; i = i + 1) begin
        mem_r[i] <= `RSIP_REG_RST;
      end
      core_rdata_r <= `RSIP_REG_RST;
    end else if (ce) begin
      if (core_we && !(bus_we && bus_addr == core_addr)) begin
        mem_r[core_addr] <= core_wdata;
      end
      if (bus_we) begin
        mem_r[bus_addr] <= bus_wdata;
      end
      core_rdata_r <= mem_r[core_addr];
    end
  end

endmodule

`default_nettype wire
